// ### hw/adc_port_pkg.sv
/*
  Shared constants for the serial ADC control and readout port:
  APB register map, field positions, reset values, timing counts
  and the link state encoding.
  Assumes a single 250 MHz pclk domain and 32-bit APB data.
*/
package adc_port_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 4;     // pclk period
  localparam int CONV_TIME_NS  = 7500;  // internal-clock conversion time
  localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_W        = 11;    // width of the conversion counter

  // serial framing
  localparam int RESULT_W   = 14;       // result word width
  localparam int FRAME_BITS = 16;       // result bits plus two zero pad bits
  localparam int CMD_BITS   = 7;        // bits following the start bit
  localparam int NUM_CH     = 8;        // analog input channels
  localparam int CFG_W      = 4;        // per-channel {diff, range}

  // configuration byte fields, counted in the seven bits after start
  localparam int CMD_CH_MSB    = 6;
  localparam int CMD_CH_LSB    = 4;
  localparam int CMD_DIFF      = 3;
  localparam int CMD_RANGE_MSB = 2;
  localparam logic [2:0] RANGE_CONVERT = 3'h0;  // range code that only converts

  // APB register byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_SAMPLE = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_MASK   = 12'h00C;
  localparam logic [11:0] OFS_CMD    = 12'h010;
  localparam logic [11:0] OFS_CFG    = 12'h014;
  localparam logic [11:0] OFS_RESULT = 12'h018;

  // field positions and reset values
  localparam int CTRL_INT_CLK = 0;           // 1: internal-clock conversions
  localparam int ST_CFG       = 0;           // a channel was configured
  localparam int ST_DONE      = 1;           // a result was loaded
  localparam int ST_READ      = 2;           // a result was shifted out fully
  localparam int EVT_W        = 3;
  localparam logic [0:0]  CTRL_RESET   = 1'h0;
  localparam logic [13:0] SAMPLE_RESET = 14'h0000;
  localparam logic [2:0]  MASK_RESET   = 3'h0;
  localparam logic [2:0]  PIN_RESET    = 3'h1;  // {sclk, din, cs_n}

  // serial link states
  typedef enum logic [2:0] {
    LINK_HUNT = 3'b001,   // searching for the start bit
    LINK_BITS = 3'b010,   // collecting the configuration byte
    LINK_CONV = 3'b100    // internal-clock conversion running
  } link_st_t;

endpackage

// ### hw/pin_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous pins.
  Assumes the pins are static levels or change far slower than clk.
*/
module pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;   // first stage, read only by the second
    logic [W-1:0] stab;   // second stage
  } sync_t;

  sync_t st;
  sync_t next_st;

  // shift the pins through both stages
  always_comb begin
    next_st      = st;
    next_st.meta = d;
    next_st.stab = st.meta;
  end

  // registers take constants only under reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= {RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.stab;

endmodule

// ### hw/adc_serial_port.sv
/*
  Serial control and readout port of a multichannel 14-bit ADC,
  with an APB register slave and a level interrupt.
  Assumes the host link pins are asynchronous to pclk and that
  serial_clock is at least several times slower than pclk.
  The analog converter is stood in for by the sample register.
*/
// Register access over APB and the address map were chosen for this implementation.
// What this block does
// - sample data in on rising serial clock
// - ignore data in while deselected
// - ignore serial clock while deselected
// - next result bit on falling clock
// - data out floats while deselected
// - strobe rises when internal result ready
// - strobe held low in external mode
// - strobe always driven, never floats
// - result word is fourteen bits
// - separate stored configuration per channel
// - config byte picks single or differential
// - eight singles or four differential pairs
// - first one after select starts byte
// - byte fields: channel, diff, range
// - pair uses positive channel, range zero converts
module adc_serial_port (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // serial link pins
  input  wire logic        chip_select_n,
  input  wire logic        serial_clock,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_out_oe,
  output logic             conversion_strobe
);

  typedef struct packed {
    adc_port_pkg::link_st_t  state;     // link state
    logic                    sclk_d;    // previous synced serial clock
    logic [2:0]              bit_cnt;   // config bits still to come
    logic [6:0]              in_shift;  // config bits after start
    logic [31:0]             cfg;       // 8 x {diff, range}
    logic [15:0]             out_shift; // result frame, msb first
    logic [4:0]              out_cnt;   // frame bits left to send
    logic [10:0]             conv_cnt;  // conversion cycles left
    logic [2:0]              conv_ch;   // channel being converted
    logic [3:0]              conv_cfg;  // its {diff, range}
    logic [0:0]              ctrl;      // control register
    logic [13:0]             sample;    // stand-in analog value
    logic [13:0]             result;    // last result loaded
    logic [2:0]              status;    // sticky events
    logic [2:0]              mask;      // interrupt mask
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    irq;
    logic                    sdo;
    logic                    sdo_oe;
    logic                    strobe;
  } port_t;

  port_t st;        // registered state
  port_t next_st;   // next value

  logic [2:0] pins_s;   // synced {sclk, din, cs_n}
  logic       cs_s;     // synced chip select, low active
  logic       sclk_s;   // synced serial clock
  logic       din_s;    // synced serial data in
  logic       sclk_rise;
  logic       sclk_fall;
  logic       byte_done;  // seventh bit after start arrives
  logic       conv_load;  // result enters the output frame
  logic [6:0] cmd;        // full command bits after start
  logic [2:0] evt;        // events this cycle
  logic       apb_setup;
  logic       apb_access;
  logic       mapped;

  // all link pins pass two flops before use
  pin_sync #(
    .W       (3),
    .RST_VAL (adc_port_pkg::PIN_RESET)
  ) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({serial_clock, serial_data_in, chip_select_n}),
    .q     (pins_s)
  );

  assign cs_s   = pins_s[0];
  assign din_s  = pins_s[1];
  assign sclk_s = pins_s[2];

  // edges only count while selected, so a deselected clock is inert
  // gate clock edges
  assign sclk_rise = !cs_s && sclk_s && !st.sclk_d;
  assign sclk_fall = !cs_s && !sclk_s && st.sclk_d;

  assign cmd        = {st.in_shift[5:0], din_s};
  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable && st.pready;

  // address decode for the setup phase
  always_comb begin
    unique case (paddr)
      adc_port_pkg::OFS_CTRL,   adc_port_pkg::OFS_SAMPLE,
      adc_port_pkg::OFS_STATUS, adc_port_pkg::OFS_MASK,
      adc_port_pkg::OFS_CMD,    adc_port_pkg::OFS_CFG,
      adc_port_pkg::OFS_RESULT: mapped = 1'b1;
      default:                  mapped = 1'b0;
    endcase
  end

  // next-state logic for link, converter and registers
  always_comb begin
    next_st        = st;
    byte_done      = 1'b0;
    conv_load      = 1'b0;
    evt            = '0;
    next_st.sclk_d = sclk_s;

    // link state machine
    unique case (st.state)
      adc_port_pkg::LINK_HUNT: begin
        if (sclk_rise && din_s) begin
          next_st.state   = adc_port_pkg::LINK_BITS;
          next_st.bit_cnt = 3'(adc_port_pkg::CMD_BITS);
        end
      end
      adc_port_pkg::LINK_BITS: begin
        if (cs_s) begin
          next_st.state   = adc_port_pkg::LINK_HUNT;
          next_st.bit_cnt = '0;
        end else if (sclk_rise) begin
          next_st.in_shift = cmd;
          next_st.bit_cnt  = st.bit_cnt - 3'h1;
          byte_done        = (st.bit_cnt == 3'h1);
        end
      end
      adc_port_pkg::LINK_CONV: begin
        // conversion runs on pclk, unaffected by chip select
        if (st.conv_cnt == '0) begin
          conv_load     = 1'b1;
          next_st.state = adc_port_pkg::LINK_HUNT;
        end else begin
          next_st.conv_cnt = st.conv_cnt - 11'h001;
        end
      end
      default: next_st.state = adc_port_pkg::LINK_HUNT;
    endcase

    // decode a complete configuration byte
    if (byte_done) begin
      next_st.state   = adc_port_pkg::LINK_HUNT;
      if (cmd[adc_port_pkg::CMD_RANGE_MSB -: 3] != adc_port_pkg::RANGE_CONVERT) begin
        next_st.cfg[cmd[adc_port_pkg::CMD_CH_MSB:adc_port_pkg::CMD_CH_LSB]*4 +: 4] =
          cmd[adc_port_pkg::CMD_DIFF:0];
        evt[adc_port_pkg::ST_CFG] = 1'b1;
      end else begin
        next_st.conv_ch = cmd[6:4];
        if (st.cfg[{cmd[6:5], 1'b0}*4 + 3] && st.cfg[cmd[6:4]*4 + 3]) begin
          next_st.conv_ch = {cmd[6:5], 1'b0};
        end
        next_st.conv_cfg = st.cfg[next_st.conv_ch*4 +: 4];
        if (st.ctrl[adc_port_pkg::CTRL_INT_CLK]) begin
          next_st.state    = adc_port_pkg::LINK_CONV;
          next_st.conv_cnt = 11'(adc_port_pkg::CONV_CYCLES - 1);
        end else begin
          // external mode: result is ready for the next falling edges
          conv_load = 1'b1;
        end
      end
    end

    if (sclk_fall) begin
      next_st.strobe = 1'b0;   // host has begun reading
      if (st.out_cnt != '0) begin
        next_st.sdo       = st.out_shift[15];
        next_st.out_shift = {st.out_shift[14:0], 1'b0};
        next_st.out_cnt   = st.out_cnt - 5'h01;
        evt[adc_port_pkg::ST_READ] = (st.out_cnt == 5'h01);
      end else begin
        next_st.sdo = 1'b0;
      end
    end

    if (conv_load) begin
      next_st.result    = st.sample;
      next_st.out_shift = {st.sample, 2'b00};
      next_st.out_cnt   = 5'(adc_port_pkg::FRAME_BITS);
      evt[adc_port_pkg::ST_DONE] = 1'b1;
      next_st.strobe = st.ctrl[adc_port_pkg::CTRL_INT_CLK];
    end

    if (!st.ctrl[adc_port_pkg::CTRL_INT_CLK]) begin
      next_st.strobe = 1'b0;
    end

    next_st.sdo_oe = !cs_s;

    // apb: pready one cycle after setup, data captured at setup
    next_st.pready  = apb_setup;
    next_st.pslverr = apb_setup && !mapped;
    if (apb_setup) begin
      next_st.prdata = '0;
      unique case (paddr)
        adc_port_pkg::OFS_CTRL:   next_st.prdata[0]     = st.ctrl;
        adc_port_pkg::OFS_SAMPLE: next_st.prdata[13:0]  = st.sample;
        adc_port_pkg::OFS_STATUS: next_st.prdata[2:0]   = st.status;
        adc_port_pkg::OFS_MASK:   next_st.prdata[2:0]   = st.mask;
        adc_port_pkg::OFS_CMD:    next_st.prdata[10:0]  = {st.state, st.conv_cfg, st.conv_ch, 1'b0};
        adc_port_pkg::OFS_CFG:    next_st.prdata        = st.cfg;
        adc_port_pkg::OFS_RESULT: next_st.prdata[13:0]  = st.result;
        default:                  next_st.prdata        = '0;
      endcase
    end

    // only the bits reported at setup are cleared, so later events survive
    next_st.status = st.status;
    if (apb_access && !pwrite && paddr == adc_port_pkg::OFS_STATUS) begin
      next_st.status = st.status & ~st.prdata[2:0];
    end
    next_st.status = next_st.status | evt;

    // register writes take effect at the access edge
    if (apb_access && pwrite) begin
      unique case (paddr)
        adc_port_pkg::OFS_CTRL:   next_st.ctrl   = pwdata[0:0];
        adc_port_pkg::OFS_SAMPLE: next_st.sample = pwdata[13:0];
        adc_port_pkg::OFS_MASK:   next_st.mask   = pwdata[2:0];
        default:                  next_st.ctrl   = st.ctrl;
      endcase
    end

    // level interrupt from the same edge as the status bits
    next_st.irq = |(next_st.status & next_st.mask);
  end

  // state register, constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.state  <= adc_port_pkg::LINK_HUNT;
      st.ctrl   <= adc_port_pkg::CTRL_RESET;
      st.sample <= adc_port_pkg::SAMPLE_RESET;
      st.mask   <= adc_port_pkg::MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign prdata             = st.prdata;
  assign pready             = st.pready;
  assign pslverr            = st.pslverr;
  assign irq                = st.irq;
  assign serial_data_out    = st.sdo;
  assign serial_data_out_oe = st.sdo_oe;
  assign conversion_strobe  = st.strobe;

  // output enable drops the cycle after deselect is seen
  property p_oe_off;
    @(posedge pclk) disable iff (!presetn)
    cs_s |=> !serial_data_out_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("data out driven while deselected");

  // deselected link never advances the output frame
  property p_no_shift_idle;
    @(posedge pclk) disable iff (!presetn)
    (cs_s && !conv_load) |=> $stable(st.out_cnt) && $stable(st.out_shift);
  endproperty
  a_no_shift_idle: assert property (p_no_shift_idle) else $error("frame moved while deselected");

  // a falling edge presents the frame msb
  property p_bit_out;
    @(posedge pclk) disable iff (!presetn)
    (sclk_fall && st.out_cnt != 5'h00) |=> serial_data_out == $past(st.out_shift[15]);
  endproperty
  a_bit_out: assert property (p_bit_out) else $error("wrong result bit presented");

  // a rising edge shifts the synced data in
  property p_bit_in;
    @(posedge pclk) disable iff (!presetn)
    (st.state == adc_port_pkg::LINK_BITS && sclk_rise) |=> st.in_shift[0] == $past(din_s);
  endproperty
  a_bit_in: assert property (p_bit_in) else $error("data in not sampled");

  // deselect mid-byte drops back to the search
  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    (st.state == adc_port_pkg::LINK_BITS && cs_s) |=> st.state == adc_port_pkg::LINK_HUNT;
  endproperty
  a_restart: assert property (p_restart) else $error("byte survived deselect");

  // strobe stays low through external mode
  property p_strobe_low;
    @(posedge pclk) disable iff (!presetn)
    !st.ctrl[0] [*2] |-> !conversion_strobe;
  endproperty
  a_strobe_low: assert property (p_strobe_low) else $error("strobe high in external mode");

  // internal conversion ends with strobe high and a full frame
  property p_strobe_ready;
    @(posedge pclk) disable iff (!presetn)
    (st.state == adc_port_pkg::LINK_CONV && st.conv_cnt == 11'h000 && st.ctrl[0])
      |=> conversion_strobe && st.out_cnt == 5'h10 && st.out_shift[15:2] == $past(st.sample);
  endproperty
  a_strobe_ready: assert property (p_strobe_ready) else $error("no strobe after conversion");

  // a range byte rewrites its channel one edge later
  property p_cfg_write;
    @(posedge pclk) disable iff (!presetn)
    (byte_done && cmd[2:0] != 3'h0) |=> st.cfg[$past(cmd[6:4])*4 +: 4] == $past(cmd[3:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("channel config not stored");

  // a convert byte leaves every stored config intact
  property p_convert_keep;
    @(posedge pclk) disable iff (!presetn)
    (byte_done && cmd[2:0] == 3'h0) |=> $stable(st.cfg);
  endproperty
  a_convert_keep: assert property (p_convert_keep) else $error("convert byte changed config");

  // a loaded frame is the fourteen-bit sample and two pad bits
  property p_frame_load;
    @(posedge pclk) disable iff (!presetn)
    conv_load |=> st.out_cnt == 5'h10 && st.out_shift == {$past(st.sample), 2'b00};
  endproperty
  a_frame_load: assert property (p_frame_load) else $error("result frame loaded wrongly");

endmodule

// ### dv/host_link_model.sv
/*
  Host-side serial master model for the ADC port bench.
  Assumes the bench resolves the data-out wire and feeds it back.
*/
module host_link_model (
  // link pins driven by the host
  output logic      chip_select_n,
  output logic      serial_clock,
  output logic      serial_data_in,
  // resolved data-out wire
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 40;  // half of the 80 ns link clock

  // idle: deselected, clock parked low between frames
  initial begin
    chip_select_n  = 1'b1;
    serial_clock   = 1'b0;
    serial_data_in = 1'b0;
  end

  // select the port
  task automatic sel();
    #HALF chip_select_n <= 1'b0;
  endtask

  // deselect; data line no longer holds its last bit
  task automatic desel();
    #HALF chip_select_n <= 1'b1;
    serial_data_in <= ~serial_data_in;
  endtask

  // start bit where the caller puts it in tx
  // shift n clocks, din msb first; dout taken before rise i when i >= fs
  task automatic xfer(input logic [23:0] tx, input int n, input int fs,
                      output logic [15:0] rx);
    rx = '0;
    for (int i = 0; i < n; i++) begin
      serial_data_in <= tx[23];
      tx = tx << 1;
      #HALF;
      if (i >= fs) begin
        rx = {rx[14:0], dout};
      end
      serial_clock <= 1'b1;
      #HALF serial_clock <= 1'b0;
    end
  endtask

  // clock and data toggling while deselected, ends with clock low
  task automatic noise(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      #HALF serial_clock <= ~serial_clock;
      serial_data_in <= ~serial_data_in;
    end
  endtask
endmodule

// ### dv/tb_multirange_adc_serial_port.sv
/*
  Self-checking bench for the serial ADC port: APB master tasks,
  a host link model, and an integer model of the channel config.
  Assumes the design answers APB with zero wait states; any wait state is counted as a failure.
*/
module tb_multirange_adc_serial_port;
  timeunit 1ns;
  timeprecision 100ps;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq, sdo, sdo_oe, strobe, err;
  logic [15:0] rx;
  wire logic   cs_n, sclk, din;
  // data-out wire shows the inverse while the port does not drive it
  wire logic   dout = sdo_oe ? sdo : ~sdo;
  int          failures, tests_run, seed, r, d, ch, ech, smp, n;
  int          cfg_m [8];  // expected {diff, range} per channel

  adc_serial_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .chip_select_n(cs_n), .serial_clock(sclk),
    .serial_data_in(din), .serial_data_out(sdo), .serial_data_out_oe(sdo_oe),
    .conversion_strobe(strobe));
  host_link_model host (.chip_select_n(cs_n), .serial_clock(sclk),
    .serial_data_in(din), .dout(dout));

  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // one APB transfer; request held until pready seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int waits;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; the slave should need no extra cycles
    waits = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      waits++;
      @(posedge pclk);
    end
    chk("pready_waits", 0, waits);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rreg(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, '0);
    chk(nm, exp, rd);
  endtask

  // whole link transaction in external mode, then idle checks
  task automatic frame(input logic [23:0] tx, input int k);
    host.sel();
    host.xfer(tx, k, 99, rx);
    host.desel();
    settle(10);
    chk("oe_idle", 0, sdo_oe);
    chk("strobe_idle", 0, strobe);
  endtask

  function automatic logic [31:0] cfg_word();
    logic [31:0] w;
    w = '0;
    for (int i = 0; i < 8; i++) w[4*i +: 4] = cfg_m[i][3:0];
    return w;
  endfunction

  // expected conversion: even channel when both of a pair are differential
  task automatic check_conv(input int c);
    ech = (cfg_m[c & 6][3] && cfg_m[c][3]) ? (c & 6) : c;
    apb(1'b0, adc_port_pkg::OFS_CMD, '0);
    chk("cmd", {cfg_m[ech][3:0], ech[2:0], 1'b0}, rd & 32'hFE);
    rreg(adc_port_pkg::OFS_RESULT, smp, "result");
  endtask

  // watchdog: the whole run needs about 35 us, so 200 us is ample
  initial begin
    #200000;
    failures++;
    finish_test();
  end

  initial begin
    seed = 32'h5A35C684;
    failures = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped address
    rreg(adc_port_pkg::OFS_CTRL, 0, "ctrl_rst");
    rreg(adc_port_pkg::OFS_SAMPLE, 0, "sample_rst");
    rreg(adc_port_pkg::OFS_MASK, 0, "mask_rst");
    rreg(adc_port_pkg::OFS_STATUS, 0, "status_rst");
    apb(1'b0, 12'hFFC, '0);
    chk("slverr", 1, err);
    chk("slverr_data", 0, rd);
    apb(1'b1, adc_port_pkg::OFS_MASK, 32'h7);
    // configure every channel, idle zeros ahead of the start bit
    for (ch = 0; ch < 8; ch++) begin
      r = (($random(seed) & 32'hFFFF) % 7) + 1;
      d = $random(seed) & 1;
      cfg_m[ch] = d * 8 + r;
      frame({3'h0, 1'b1, ch[2:0], d[0], r[2:0], 13'h0}, 11);
      chk("irq_cfg", 1, irq);
      rreg(adc_port_pkg::OFS_STATUS, 1, "st_cfg");
      settle(1);
      chk("irq_clr", 0, irq);
    end
    rreg(adc_port_pkg::OFS_CFG, cfg_word(), "cfg_all");
    // aborted byte, then a fresh one must align
    host.sel();
    host.xfer(24'hF00000, 4, 99, rx);
    host.desel();
    cfg_m[5] = 7;
    frame(24'hD70000, 8);
    rreg(adc_port_pkg::OFS_STATUS, 1, "st_realign");
    // noise while deselected must not shift anything
    host.noise(40);
    settle(10);
    rreg(adc_port_pkg::OFS_STATUS, 0, "st_abort");
    // channel 2 as a differential pair
    cfg_m[2] = 12;
    cfg_m[3] = 9;
    frame(24'hAC0000, 8);
    frame(24'hB90000, 8);
    rreg(adc_port_pkg::OFS_STATUS, 1, "st_pair");
    // external conversions, pair first; done masked, read unmasked
    apb(1'b1, adc_port_pkg::OFS_MASK, 32'h5);
    for (n = 0; n < 5; n++) begin
      ch = (n == 0) ? 2 : (n == 1) ? 3 : ($random(seed) & 7);
      smp = $random(seed) & 32'h3FFF;
      apb(1'b1, adc_port_pkg::OFS_SAMPLE, smp);
      host.sel();
      host.xfer({1'b1, ch[2:0], 4'h0, 16'h0}, 8, 99, rx);
      settle(10);
      chk("irq_masked", 0, irq);
      chk("strobe_ext", 0, strobe);
      host.xfer(24'h0, 16, 0, rx);
      chk("frame_ext", {smp[13:0], 2'b00}, rx);
      host.desel();
      settle(10);
      chk("irq_read", 1, irq);
      rreg(adc_port_pkg::OFS_STATUS, 6, "st_ext");
      check_conv(ch);
    end
    rreg(adc_port_pkg::OFS_CFG, cfg_word(), "cfg_kept");
    // internal-clock conversion on channel 6
    apb(1'b1, adc_port_pkg::OFS_CTRL, 32'h1);
    smp = $random(seed) & 32'h3FFF;
    apb(1'b1, adc_port_pkg::OFS_SAMPLE, smp);
    host.sel();
    host.xfer(24'hE00000, 8, 99, rx);
    for (n = 0; n < 3000 && strobe !== 1'b1; n++) @(posedge pclk);
    chk("strobe_int", 1, strobe);
    chk("conv_time", 1, n > adc_port_pkg::CONV_CYCLES - 30);
    host.xfer(24'h0, 17, 1, rx);
    chk("frame_int", {smp[13:0], 2'b00}, rx);
    chk("strobe_low", 0, strobe);
    host.desel();
    settle(10);
    rreg(adc_port_pkg::OFS_STATUS, 6, "st_int");
    check_conv(6);
    chk("oe_int", 0, sdo_oe);
    finish_test();
  end
endmodule
